// ---- core/canphy_irq_pkg.sv ----
`default_nettype none
package canphy_irq_pkg;
   // register bus geometry
   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   // byte offsets, one 8-bit register per byte address
   localparam int IDX_PIN_DATA = 12'h990;
   localparam int IDX_CONTROL = 12'h991;
   localparam int IDX_STATUS = 12'h993;
   localparam int IDX_IRQ_ENABLE = 12'h996;
   localparam int IDX_IRQ_FLAGS = 12'h997;
   localparam int WORD_BYTES = 1;
   localparam logic [ADDR_W-1:0] ADDR_PIN_DATA =
      ADDR_W'(IDX_PIN_DATA * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_CONTROL =
      ADDR_W'(IDX_CONTROL * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_STATUS =
      ADDR_W'(IDX_STATUS * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE =
      ADDR_W'(IDX_IRQ_ENABLE * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS =
      ADDR_W'(IDX_IRQ_FLAGS * WORD_BYTES);
   // flag and status bit positions
   localparam int BIT_CANH_HIGH = 7;
   localparam int BIT_CANH_LOW = 6;
   localparam int BIT_CANL_HIGH = 5;
   localparam int BIT_CANL_LOW = 4;
   localparam int BIT_TX_DOM = 3;
   localparam int BIT_CANH_OC = 1;
   localparam int BIT_CANL_OC = 0;
   // enable bit positions
   localparam int EN_VOLT_FAIL = 4;
   localparam int EN_TX_DOM = 3;
   localparam int EN_OVERCURRENT = 0;
   // implemented bits and groups
   localparam logic [DATA_W-1:0] FLAGS_IMPL = 8'hFB;
   localparam logic [DATA_W-1:0] ENABLE_IMPL = 8'h19;
   localparam logic [DATA_W-1:0] STATUS_IMPL = 8'hF8;
   localparam logic [DATA_W-1:0] PIN_DATA_IMPL = 8'h83;
   localparam logic [DATA_W-1:0] BOTH_EDGE_BITS = 8'hF0;
   localparam logic [DATA_W-1:0] GROUP_VOLT = 8'hF0;
   localparam logic [DATA_W-1:0] GROUP_TX_DOM = 8'h08;
   localparam logic [DATA_W-1:0] GROUP_OC = 8'h03;
   // reset value and detector arming delay in cycles
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] ARM_CYCLES = 2'h3;

   // flag bits allowed to request an interrupt under a given enable byte
   function automatic logic [DATA_W-1:0] groupMask(
      input logic [DATA_W-1:0] en);
      groupMask = ({DATA_W{en[EN_VOLT_FAIL]}} & GROUP_VOLT)
         | ({DATA_W{en[EN_TX_DOM]}} & GROUP_TX_DOM)
         | ({DATA_W{en[EN_OVERCURRENT]}} & GROUP_OC);
   endfunction : groupMask
endpackage : canphy_irq_pkg
`default_nettype wire

// ---- core/fault_event_if.sv ----
`default_nettype none
interface fault_event_if #(parameter int W = 8);
   logic [W-1:0] changeEvt;
   logic [W-1:0] syncLevel;
   logic armed;
   modport src (output changeEvt, output syncLevel, output armed);
   modport dst (input changeEvt, input syncLevel, input armed);
endinterface : fault_event_if
`default_nettype wire

// ---- core/fault_event_detect.sv ----
`default_nettype none
module fault_event_detect #(
   parameter int W = 8,
   parameter logic [W-1:0] BOTH_EDGES = canphy_irq_pkg::BOTH_EDGE_BITS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw fault levels
   input wire logic [W-1:0] rawIn,
   // detected events
   fault_event_if.src evt
);
   import canphy_irq_pkg::*;

   logic [1:0] armCnt_reg, armCnt_next;

   // no events until the chains hold real samples, else reset fakes edges
   always_comb begin
      armCnt_next = armCnt_reg;
      if (armCnt_reg != ARM_CYCLES) begin
         armCnt_next = armCnt_reg + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         armCnt_reg <= 2'h0;
      end else begin
         armCnt_reg <= armCnt_next;
      end
   end

   assign evt.armed = (armCnt_reg == ARM_CYCLES);

   for (genvar gi = 0; gi < W; gi++) begin : g_bit
      // [0] first stage, [1] stable, [2] previous stable
      logic [2:0] chain_reg, chain_next;

      always_comb begin
         chain_next = {chain_reg[1:0], rawIn[gi]};
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            chain_reg <= 3'h0;
         end else begin
            chain_reg <= chain_next;
         end
      end

      assign evt.syncLevel[gi] = chain_reg[1];
      assign evt.changeEvt[gi] = evt.armed
         & ((chain_reg[1] & ~chain_reg[2])
         | (BOTH_EDGES[gi] & ~chain_reg[1] & chain_reg[2]));
   end
endmodule : fault_event_detect
`default_nettype wire

// ---- core/can_phy_fault_interrupt_flags.sv ----
// Overview of operation
// - overcurrent enable bit 0 gates both overcurrent flags onto interrupt.
// - flags read anytime; writing 1 clears a flag, writing 0 keeps it.
// - interrupt pending while any flag and its group enable are set.
// - CANH high fail flag, bit 7, sets on any status change.
// - CANH low fail flag, bit 6, sets on any status change.
// - voltage fail enable bit 4 gates four voltage flags onto interrupt.
// - tx dominant timeout enable bit 3 gates its flag onto interrupt.
//
// Our own choice: the plain strobed port.
`default_nettype none
module can_phy_fault_interrupt_flags (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [canphy_irq_pkg::ADDR_W-1:0] addr,
   input wire logic [canphy_irq_pkg::DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [canphy_irq_pkg::DATA_W-1:0] rdData,
   // fault levels from the transceiver
   input wire logic canhHighFailStatus,
   input wire logic canhLowFailStatus,
   input wire logic canlHighFailStatus,
   input wire logic canlLowFailStatus,
   input wire logic txDomTimeoutStatus,
   input wire logic canhOvercurrent,
   input wire logic canlOvercurrent,
   // control outputs
   output logic [canphy_irq_pkg::DATA_W-1:0] phyControl,
   output logic [canphy_irq_pkg::DATA_W-1:0] phyPinDataOut,
   // interrupt
   output logic errorIrq
);
   import canphy_irq_pkg::*;

   fault_event_if #(.W(DATA_W)) evtIf ();

   logic [DATA_W-1:0] rawFaults;
   logic [DATA_W-1:0] flags_reg, flags_next;
   logic [DATA_W-1:0] enable_reg, enable_next;
   logic [DATA_W-1:0] control_reg, control_next;
   logic [DATA_W-1:0] pinData_reg, pinData_next;
   logic [DATA_W-1:0] rdData_reg, rdData_next;
   logic irq_reg, irq_next;
   logic wrFlags, wrEnable, wrControl, wrPinData;
   logic [DATA_W-1:0] clearMask;
   logic [DATA_W-1:0] statusView;

   // fault levels laid out like the flag register
   always_comb begin
      rawFaults = RESET_BYTE;
      rawFaults[BIT_CANH_HIGH] = canhHighFailStatus;
      rawFaults[BIT_CANH_LOW] = canhLowFailStatus;
      rawFaults[BIT_CANL_HIGH] = canlHighFailStatus;
      rawFaults[BIT_CANL_LOW] = canlLowFailStatus;
      rawFaults[BIT_TX_DOM] = txDomTimeoutStatus;
      rawFaults[BIT_CANH_OC] = canhOvercurrent;
      rawFaults[BIT_CANL_OC] = canlOvercurrent;
   end

   // voltage bits flag both edges, the others only onset
   fault_event_detect #(
      .W(DATA_W),
      .BOTH_EDGES(BOTH_EDGE_BITS)
   ) u_detect (
      .clk(clk),
      .rst(rst),
      .rawIn(rawFaults),
      .evt(evtIf.src)
   );

   // status shows only the voltage and timeout levels
   assign statusView = evtIf.syncLevel & STATUS_IMPL;

   // write decode
   always_comb begin
      wrFlags = wrStrobe && (addr == ADDR_IRQ_FLAGS);
      wrEnable = wrStrobe && (addr == ADDR_IRQ_ENABLE);
      wrControl = wrStrobe && (addr == ADDR_CONTROL);
      wrPinData = wrStrobe && (addr == ADDR_PIN_DATA);
      clearMask = wrFlags ? wrData : RESET_BYTE;
   end

   // flag update
   always_comb begin
      // write one clears
      // a new event beats a clear in the same cycle so it is never lost
      flags_next = flags_reg & ~clearMask;
      flags_next = (flags_next | evtIf.changeEvt) & FLAGS_IMPL;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= RESET_BYTE;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // configuration registers
   always_comb begin
      enable_next = enable_reg;
      control_next = control_reg;
      pinData_next = pinData_reg;
      if (wrEnable) begin
         enable_next = wrData & ENABLE_IMPL;
      end
      if (wrControl) begin
         control_next = wrData;
      end
      if (wrPinData) begin
         pinData_next = wrData & PIN_DATA_IMPL;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         enable_reg <= RESET_BYTE;
         control_reg <= RESET_BYTE;
         pinData_reg <= RESET_BYTE;
      end else begin
         enable_reg <= enable_next;
         control_reg <= control_next;
         pinData_reg <= pinData_next;
      end
   end

   // interrupt from next values keeps the output aligned with the flags
   always_comb begin
      irq_next = |(flags_next & groupMask(enable_next));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // read path, data valid only the cycle after the strobe
   always_comb begin
      rdData_next = RESET_BYTE;
      if (rdStrobe) begin
         case (addr)
            ADDR_PIN_DATA: begin
               rdData_next = pinData_reg;
            end
            ADDR_CONTROL: begin
               rdData_next = control_reg;
            end
            ADDR_STATUS: begin
               rdData_next = statusView;
            end
            ADDR_IRQ_ENABLE: begin
               rdData_next = enable_reg;
            end
            ADDR_IRQ_FLAGS: begin
               rdData_next = flags_reg;
            end
            default: begin
               rdData_next = RESET_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_reg <= RESET_BYTE;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   assign rdData = rdData_reg;
   assign errorIrq = irq_reg;
   assign phyControl = control_reg;
   assign phyPinDataOut = pinData_reg;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_oc_gate;
      (enable_reg[EN_OVERCURRENT] && |(flags_reg & GROUP_OC))
         |-> errorIrq;
   endproperty
   a_oc_gate: assert property (p_oc_gate)
      else $error("overcurrent flag enabled but no interrupt");

   property p_oc_masked;
      (!enable_reg[EN_OVERCURRENT] && !enable_reg[EN_VOLT_FAIL]
         && !enable_reg[EN_TX_DOM]) |-> !errorIrq;
   endproperty
   a_oc_masked: assert property (p_oc_masked)
      else $error("interrupt raised with all enables off");

   property p_w1c_clear;
      (wrFlags && wrData[BIT_CANH_OC] && !evtIf.changeEvt[BIT_CANH_OC])
         |=> !flags_reg[BIT_CANH_OC];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear)
      else $error("write one did not clear flag");

   property p_w0_keep;
      (!wrFlags || !wrData[BIT_CANH_HIGH]) && flags_reg[BIT_CANH_HIGH]
         |=> flags_reg[BIT_CANH_HIGH];
   endproperty
   a_w0_keep: assert property (p_w0_keep)
      else $error("flag lost without a write of one");

   property p_flags_read;
      (rdStrobe && addr == ADDR_IRQ_FLAGS)
         |=> (rdData == $past(flags_reg)) ##1 (rdData == RESET_BYTE
         || $past(rdStrobe));
   endproperty
   a_flags_read: assert property (p_flags_read)
      else $error("flag readback wrong or held too long");

   property p_pending;
      errorIrq == |(flags_reg & groupMask(enable_reg));
   endproperty
   a_pending: assert property (p_pending)
      else $error("pending interrupt disagrees with flags");

   property p_canh_high;
      (evtIf.armed && $changed(evtIf.syncLevel[BIT_CANH_HIGH]))
         |=> flags_reg[BIT_CANH_HIGH];
   endproperty
   a_canh_high: assert property (p_canh_high)
      else $error("CANH high change not flagged");

   property p_canh_low;
      (evtIf.armed && $changed(evtIf.syncLevel[BIT_CANH_LOW]))
         |=> flags_reg[BIT_CANH_LOW];
   endproperty
   a_canh_low: assert property (p_canh_low)
      else $error("CANH low change not flagged");

   property p_canh_low_quiet;
      (!flags_reg[BIT_CANH_LOW] && $stable(evtIf.syncLevel[BIT_CANH_LOW])
         && !$changed(rawFaults[BIT_CANH_LOW])) ##1
         $stable(evtIf.syncLevel[BIT_CANH_LOW])
         |-> !flags_reg[BIT_CANH_LOW];
   endproperty
   a_canh_low_quiet: assert property (p_canh_low_quiet)
      else $error("CANH low flag set without change");

   property p_volt_gate;
      (enable_reg[EN_VOLT_FAIL] && |(flags_reg & GROUP_VOLT))
         |-> errorIrq;
   endproperty
   a_volt_gate: assert property (p_volt_gate)
      else $error("voltage flag enabled but no interrupt");

   property p_txdom_gate;
      (enable_reg[EN_TX_DOM] && flags_reg[BIT_TX_DOM]) |-> errorIrq;
   endproperty
   a_txdom_gate: assert property (p_txdom_gate)
      else $error("timeout flag enabled but no interrupt");

   property p_canl_change;
      (evtIf.armed && ($changed(evtIf.syncLevel[BIT_CANL_HIGH])
         || $changed(evtIf.syncLevel[BIT_CANL_LOW])))
         |=> (flags_reg[BIT_CANL_HIGH] || flags_reg[BIT_CANL_LOW]);
   endproperty
   a_canl_change: assert property (p_canl_change)
      else $error("CANL change not flagged");

   property p_pin_to_flag;
      (evtIf.armed && $rose(canhHighFailStatus) && !wrFlags)
         |-> ##[2:4] flags_reg[BIT_CANH_HIGH];
   endproperty
   a_pin_to_flag: assert property (p_pin_to_flag)
      else $error("CANH high pin change not flagged in time");

   // disabled groups must stay quiet even with flags set
   property p_oc_off;
      (!enable_reg[EN_OVERCURRENT] && (flags_reg & ~GROUP_OC) == RESET_BYTE)
         |-> !errorIrq;
   endproperty
   a_oc_off: assert property (p_oc_off)
      else $error("overcurrent flag raised interrupt while disabled");

   property p_volt_masked;
      (!enable_reg[EN_VOLT_FAIL] && (flags_reg & ~GROUP_VOLT) == RESET_BYTE)
         |-> !errorIrq;
   endproperty
   a_volt_masked: assert property (p_volt_masked)
      else $error("voltage flag raised interrupt while disabled");

   property p_txdom_masked;
      (!enable_reg[EN_TX_DOM] && (flags_reg & ~GROUP_TX_DOM) == RESET_BYTE)
         |-> !errorIrq;
   endproperty
   a_txdom_masked: assert property (p_txdom_masked)
      else $error("timeout flag raised interrupt while disabled");

   property p_canl_high;
      (evtIf.armed && $changed(evtIf.syncLevel[BIT_CANL_HIGH]))
         |=> flags_reg[BIT_CANL_HIGH];
   endproperty
   a_canl_high: assert property (p_canl_high)
      else $error("CANL high change not flagged");

   property p_canl_low;
      (evtIf.armed && $changed(evtIf.syncLevel[BIT_CANL_LOW]))
         |=> flags_reg[BIT_CANL_LOW];
   endproperty
   a_canl_low: assert property (p_canl_low)
      else $error("CANL low change not flagged");

   property p_status_view;
      (rdStrobe && addr == ADDR_STATUS)
         |=> rdData == ($past(evtIf.syncLevel) & STATUS_IMPL);
   endproperty
   a_status_view: assert property (p_status_view)
      else $error("status readback disagrees with fault levels");

   // read data must not linger, software may poll other addresses
   property p_read_idle;
      !rdStrobe |=> rdData == RESET_BYTE;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data left standing without a read");

   property p_reserved_zero;
      (flags_reg & ~FLAGS_IMPL) == RESET_BYTE;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved flag bit set");

   c_masked_flag: cover property (flags_reg != RESET_BYTE && !errorIrq);
   c_irq_rise: cover property ($rose(errorIrq));
   c_clear_flag: cover property (
      flags_reg[BIT_CANL_LOW] && wrFlags && wrData[BIT_CANL_LOW]
      ##1 !flags_reg[BIT_CANL_LOW]);
   c_set_and_clear: cover property (
      wrFlags && wrData[BIT_CANH_HIGH] && evtIf.changeEvt[BIT_CANH_HIGH]);
   c_read_flags: cover property (
      rdStrobe && addr == ADDR_IRQ_FLAGS && flags_reg != RESET_BYTE);
endmodule : can_phy_fault_interrupt_flags
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
module tb_top import canphy_irq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData;
   logic wrStrobe;
   logic rdStrobe;
   logic [7:0] faults;
   wire logic [DATA_W-1:0] rdData;
   wire logic [DATA_W-1:0] phyControl;
   wire logic [DATA_W-1:0] phyPinDataOut;
   wire logic errorIrq;
   int n_errors = 0;
   int samples_checked = 0;
   integer seed = 32'h6F73;
   logic [7:0] expQ[$];
   logic rdPend = 1'b0;

   always #4 clk = ~clk;

   can_phy_fault_interrupt_flags i_can_phy_fault_interrupt_flags (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
      .canhHighFailStatus(faults[7]), .canhLowFailStatus(faults[6]),
      .canlHighFailStatus(faults[5]), .canlLowFailStatus(faults[4]),
      .txDomTimeoutStatus(faults[3]), .canhOvercurrent(faults[1]),
      .canlOvercurrent(faults[0]), .phyControl(phyControl),
      .phyPinDataOut(phyPinDataOut), .errorIrq(errorIrq));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
         input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s: seen %h expected %h", $time,
            what, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   // both strobes dropped here, and wr and rd each drop the other one, so no signal is driven twice per step
   task automatic idle(input int n);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      rdStrobe <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      addr <= a;
      rdStrobe <= 1'b1;
      wrStrobe <= 1'b0;
      expQ.push_back(e);
      @(posedge clk);
   endtask : rd

   task automatic irq(input logic e);
      idle(1);
      @(negedge clk);
      check({7'h00, errorIrq}, {7'h00, e}, "interrupt level");
      @(posedge clk);
   endtask : irq

   // sync chain plus history needs three edges; four leaves margin
   task automatic fault(input logic [7:0] v);
      faults <= v;
      idle(4);
   endtask : fault

   always @(posedge clk) begin
      rdPend <= rdStrobe;
   end

   // read data stands one cycle only, so sample mid-cycle
   always @(negedge clk) begin
      if (rdPend) begin
         if (expQ.size() == 0) begin
            check(8'h00, 8'hFF, "read without a note");
         end else begin
            check(rdData, expQ.pop_front(), "read data");
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      results();
   end

   initial begin
      logic [7:0] m;
      logic [7:0] v;
      logic [7:0] r;
      logic [7:0] grpF[3];
      logic [7:0] enB[3];
      grpF = '{GROUP_VOLT, GROUP_TX_DOM, GROUP_OC};
      enB = '{8'h10, 8'h08, 8'h01};
      addr = '0;
      wrData = 8'h00;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      faults = 8'h00;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      idle(4);
      rd(ADDR_IRQ_FLAGS, RESET_BYTE);
      rd(ADDR_IRQ_ENABLE, 8'h00);
      rd(ADDR_CONTROL, 8'h00);
      irq(1'b0);
      $display("test reset values done");
      v = 8'($random(seed));
      wr(ADDR_CONTROL, v);
      rd(ADDR_CONTROL, v);
      r = 8'($random(seed));
      wr(ADDR_PIN_DATA, r);
      rd(ADDR_PIN_DATA, r & PIN_DATA_IMPL);
      wr(ADDR_IRQ_ENABLE, 8'hFF);
      rd(ADDR_IRQ_ENABLE, ENABLE_IMPL);
      wr(ADDR_CONTROL + 14'h4, 8'hFF);
      rd(ADDR_CONTROL + 14'h4, 8'h00);
      rd(ADDR_IRQ_FLAGS + 14'h4, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      idle(1);
      @(negedge clk);
      check(phyControl, v, "control output");
      check(phyPinDataOut, r & PIN_DATA_IMPL, "pin data output");
      @(posedge clk);
      $display("test register map done");
      // each flag: set, survive a zero write, clear, then falling change
      for (int b = 7; b >= 0; b--) begin
         if (FLAGS_IMPL[b]) begin
            m = 8'h01 << b;
            fault(m);
            rd(ADDR_STATUS, m & STATUS_IMPL);
            rd(ADDR_IRQ_FLAGS, m);
            irq(1'b1);
            wr(ADDR_IRQ_FLAGS, ~m);
            rd(ADDR_IRQ_FLAGS, m);
            wr(ADDR_IRQ_FLAGS, m);
            irq(1'b0);
            rd(ADDR_IRQ_FLAGS, 8'h00);
            fault(8'h00);
            rd(ADDR_IRQ_FLAGS, m & BOTH_EDGE_BITS);
            wr(ADDR_IRQ_FLAGS, 8'hFF);
         end
      end
      $display("test flag events done");
      // each group alone: gated by its own enable only
      for (int k = 0; k < 3; k++) begin
         fault(8'h00);
         wr(ADDR_IRQ_FLAGS, 8'hFF);
         fault(grpF[k]);
         rd(ADDR_IRQ_FLAGS, grpF[k]);
         wr(ADDR_IRQ_ENABLE, ENABLE_IMPL & ~enB[k]);
         irq(1'b0);
         wr(ADDR_IRQ_ENABLE, enB[k]);
         irq(1'b1);
         r = 8'($random(seed));
         wr(ADDR_IRQ_FLAGS, r & ~grpF[k]);
         rd(ADDR_IRQ_FLAGS, grpF[k]);
         irq(1'b1);
         wr(ADDR_IRQ_FLAGS, grpF[k]);
         irq(1'b0);
      end
      $display("test group enables done");
      idle(3);
      results();
   end
endmodule : tb_top
`default_nettype wire
